// ===== pkg/gpcfg_map.svh
`ifndef GPCFG_MAP_SVH
`define GPCFG_MAP_SVH
`define GPCFG_PIN_ENABLE_OFFSET    32'h01b00000
`define GPCFG_PIN_DIRECTION_OFFSET 32'h01b00004
`define GPCFG_PIN_ENABLE_RESET     16'h0000
`define GPCFG_PIN_DIRECTION_RESET  16'h0000
`define GPCFG_PIN_COUNT            16
`define GPCFG_RESP_OKAY            2'h0
`define GPCFG_RESP_SLVERR          2'h2
`endif

// ===== pkg/gpcfg_pkg.sv
package gpcfg_pkg;
   typedef enum logic [1:0] {GPCFG_REG_ENABLE, GPCFG_REG_DIRECTION, GPCFG_REG_NONE} gpcfg_reg_e;
   typedef logic [15:0] gpcfg_pins_t;
   typedef struct packed {
      gpcfg_pins_t pin_enable_register;
      gpcfg_pins_t pin_direction_register;
      gpcfg_pins_t pins_out;
      gpcfg_pins_t pins_oe;
      gpcfg_pins_t pins_in;
      logic        awready;
      logic        wready;
      logic        aw_held;
      logic        w_held;
      logic [31:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } gpcfg_state_s;
endpackage

// ===== hdl/gpcfg_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpcfg_map.svh"
// What this block does
// RL1: Each of sixteen pins has an enable bit; pin is general-purpose only when 1.
// RL2: Direction bit 0 makes an enabled pin an input, never driven.
// RL3: Direction bit 1 makes an enabled pin a driven output.
// RL4: Direction only matters while the matching enable bit is 1.
// RL5: After reset every pin is an input; direction bits read zero. Enable also resets to 0 here, so each pin follows alt_oe.
// RL6: Enable register at 01B00000, direction at 01B00004, both read/write.
// RL7: Disabled pins are left to the alternate function or undriven.
module gpcfg_top
   import gpcfg_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   // AXI4-Lite write
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Alternate function sharing the pins
   input  wire logic [15:0] alt_out,
   input  wire logic [15:0] alt_oe,
   // General-purpose pins
   input  wire logic [15:0] general_io_pins_in,
   output var  logic [15:0] general_io_pins_out,
   output var  logic [15:0] general_io_pins_oe,
   // Configuration and sampled input
   output var  logic [15:0] pin_enable_bit,
   output var  logic [15:0] pin_direction_bit,
   output var  logic [15:0] gpio_in_value
);

   gpcfg_state_s state_q;
   gpcfg_state_s state_d;

   function automatic gpcfg_reg_e decode(input logic [31:0] addr);
      if (addr == `GPCFG_PIN_ENABLE_OFFSET)
         decode = GPCFG_REG_ENABLE; // RL6
      else if (addr == `GPCFG_PIN_DIRECTION_OFFSET)
         decode = GPCFG_REG_DIRECTION; // RL6
      else
         decode = GPCFG_REG_NONE;
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
      merge = old;
      if (strb[0])
         merge[7:0] = data[7:0];
      if (strb[1])
         merge[15:8] = data[15:8];
   endfunction

   logic        wr_go;
   gpcfg_reg_e  wr_sel;
   gpcfg_reg_e  rd_sel;

   // Per-pin next drive, built one slice per pin below
   wire logic [15:0] pins_oe_d;
   wire logic [15:0] pins_out_d;

   always_comb
   begin
      wr_go  = state_q.aw_held && state_q.w_held && !state_q.bvalid;
      wr_sel = decode(state_q.aw_addr);
      rd_sel = decode(s_axi_araddr);
      state_d = state_q;
      // Address and data are latched separately so either may come first
      if (s_axi_awvalid && state_q.awready)
      begin
         state_d.aw_addr = s_axi_awaddr;
         state_d.aw_held = 1'b1;
         state_d.awready = 1'b0;
      end
      if (s_axi_wvalid && state_q.wready)
      begin
         state_d.w_data = s_axi_wdata;
         state_d.w_strb = s_axi_wstrb;
         state_d.w_held = 1'b1;
         state_d.wready = 1'b0;
      end
      if (wr_go)
      begin
         state_d.bvalid = 1'b1;
         state_d.bresp  = `GPCFG_RESP_OKAY;
         case (wr_sel)
            GPCFG_REG_ENABLE:
               state_d.pin_enable_register =
                  merge(state_q.pin_enable_register, state_q.w_data, state_q.w_strb); // RL6
            GPCFG_REG_DIRECTION:
               state_d.pin_direction_register =
                  merge(state_q.pin_direction_register, state_q.w_data, state_q.w_strb); // RL6
            default:
               state_d.bresp = `GPCFG_RESP_SLVERR;
         endcase
      end
      if (state_q.bvalid && s_axi_bready)
      begin
         state_d.bvalid  = 1'b0;
         state_d.aw_held = 1'b0;
         state_d.w_held  = 1'b0;
         state_d.awready = 1'b1;
         state_d.wready  = 1'b1;
      end
      // Read: one outstanding, arready drops while the answer waits
      if (s_axi_arvalid && state_q.arready)
      begin
         state_d.arready = 1'b0;
         state_d.rvalid  = 1'b1;
         state_d.rresp   = `GPCFG_RESP_OKAY;
         case (rd_sel)
            GPCFG_REG_ENABLE:
               state_d.rdata = {16'h0000, state_q.pin_enable_register}; // RL6
            GPCFG_REG_DIRECTION:
               state_d.rdata = {16'h0000, state_q.pin_direction_register}; // RL6
            default:
            begin
               state_d.rdata = 32'h00000000;
               state_d.rresp = `GPCFG_RESP_SLVERR;
            end
         endcase
      end
      if (state_q.rvalid && s_axi_rready)
      begin
         state_d.rvalid  = 1'b0;
         state_d.arready = 1'b1;
      end
      // Pin drive comes from the per-pin slices
      state_d.pins_oe  = pins_oe_d; // RL2 RL3
      state_d.pins_out = pins_out_d; // RL7
      // Enabled inputs are sampled; others read as zero
      state_d.pins_in = general_io_pins_in & state_q.pin_enable_register &
                        ~state_q.pin_direction_register; // RL2
   end

   always_ff @(posedge clk)
   begin
      // Reset is not gated by clk_en so a frozen block still returns to a known state
      if (!reset_n)
      begin
         state_q                        <= '0;
         state_q.pin_enable_register    <= `GPCFG_PIN_ENABLE_RESET;
         state_q.pin_direction_register <= `GPCFG_PIN_DIRECTION_RESET; // RL5
         state_q.awready                <= 1'b1;
         state_q.wready                 <= 1'b1;
         state_q.arready                <= 1'b1;
      end
      else if (clk_en)
         state_q <= state_d;
   end

   // Readies keep their value while frozen: a master must not hand over while clk_en is low
   assign s_axi_awready       = state_q.awready;
   assign s_axi_wready        = state_q.wready;
   assign s_axi_bvalid        = state_q.bvalid;
   assign s_axi_bresp         = state_q.bresp;
   assign s_axi_arready       = state_q.arready;
   assign s_axi_rvalid        = state_q.rvalid;
   assign s_axi_rdata         = state_q.rdata;
   assign s_axi_rresp         = state_q.rresp;
   assign general_io_pins_out = state_q.pins_out;
   assign general_io_pins_oe  = state_q.pins_oe;
   assign pin_enable_bit      = state_q.pin_enable_register;
   assign pin_direction_bit   = state_q.pin_direction_register;
   assign gpio_in_value       = state_q.pins_in;

   // Checks
   sequence s_input_cfg(int i);
      state_q.pin_enable_register[i] && !state_q.pin_direction_register[i];
   endsequence

   sequence s_write_pair;
      state_q.aw_held && state_q.w_held && !state_q.bvalid;
   endsequence

   sequence s_write_answer;
      s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endsequence

   // One slice per pin; a disabled pin hands its pad to the alternate function
   for (genvar g = 0; g < `GPCFG_PIN_COUNT; g++)
   begin : g_pin
      // Enabled outputs drive 0 because this block holds no output data register
      assign pins_oe_d[g]  = state_q.pin_enable_register[g] ? // RL1 RL4
                             state_q.pin_direction_register[g] : alt_oe[g]; // RL2 RL3
      assign pins_out_d[g] = state_q.pin_enable_register[g] ? 1'b0 : alt_out[g]; // RL7

      chk_pin_input: assert property (@(posedge clk) disable iff (!reset_n) // RL2
         clk_en and s_input_cfg(g) |=> !general_io_pins_oe[g])
         else $error("Enabled input pin is driven");

      chk_pin_sample: assert property (@(posedge clk) disable iff (!reset_n) // RL2
         clk_en and s_input_cfg(g) |=> gpio_in_value[g] == $past(general_io_pins_in[g]))
         else $error("Enabled input pin not sampled");

      chk_pin_output: assert property (@(posedge clk) disable iff (!reset_n) // RL3
         clk_en && pin_enable_bit[g] && pin_direction_bit[g]
         |=> general_io_pins_oe[g] && !general_io_pins_out[g])
         else $error("Enabled output pin not driven low");

      chk_pin_masked: assert property (@(posedge clk) disable iff (!reset_n) // RL1
         clk_en && !(pin_enable_bit[g] && !pin_direction_bit[g]) |=> !gpio_in_value[g])
         else $error("Pin that is not an enabled input reads as set");

      chk_pin_alt: assert property (@(posedge clk) disable iff (!reset_n) // RL7
         clk_en && !pin_enable_bit[g]
         |=> general_io_pins_oe[g] == $past(alt_oe[g])
             && general_io_pins_out[g] == $past(alt_out[g]))
         else $error("Disabled pin does not follow alternate function");
   end

   chk_input_undriven: assert property (@(posedge clk) disable iff (!reset_n) // RL2
      clk_en and s_input_cfg(0) |=> !general_io_pins_oe[0])
      else $error("Enabled input pin 0 is driven");

   chk_output_driven: assert property (@(posedge clk) disable iff (!reset_n) // RL3
      clk_en && pin_enable_bit[0] && pin_direction_bit[0] |=> general_io_pins_oe[0])
      else $error("Enabled output pin 0 not driven");

   chk_gp_enable_gate: assert property (@(posedge clk) disable iff (!reset_n) // RL1
      clk_en && !pin_enable_bit[1] && !alt_oe[1] |=> !general_io_pins_oe[1])
      else $error("Disabled pin 1 driven without alternate request");

   chk_dir_ignored: assert property (@(posedge clk) disable iff (!reset_n) // RL4
      clk_en && !pin_enable_bit[2] |=> general_io_pins_oe[2] == $past(alt_oe[2]))
      else $error("Direction leaked onto disabled pin 2");

   chk_alt_passthru: assert property (@(posedge clk) disable iff (!reset_n) // RL7
      clk_en && !pin_enable_bit[3] |=> general_io_pins_out[3] == $past(alt_out[3]))
      else $error("Disabled pin 3 does not follow alternate function");

   chk_reset_inputs: assert property (@(posedge clk) // RL5
      !reset_n |=> pin_direction_bit == 16'h0000 && general_io_pins_oe == 16'h0000)
      else $error("Pins not inputs after reset");

   chk_dir_write: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && wr_go && wr_sel == GPCFG_REG_DIRECTION && state_q.w_strb == 4'hf
      |=> pin_direction_bit == $past(state_q.w_data[15:0]))
      else $error("Direction register write lost");

   chk_enable_read: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && s_axi_arvalid && s_axi_arready && rd_sel == GPCFG_REG_ENABLE
      |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(pin_enable_bit))
      else $error("Enable register readback wrong");

   chk_write_answer: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en and s_write_pair |=> s_write_answer)
      else $error("Write response missing after address and data");

   chk_write_release: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("Write channel not released after response");

   chk_enable_write: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && wr_go && wr_sel == GPCFG_REG_ENABLE && state_q.w_strb == 4'hf
      |=> pin_enable_bit == $past(state_q.w_data[15:0]))
      else $error("Enable register write lost");

   chk_unmapped_write: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && wr_go && wr_sel == GPCFG_REG_NONE
      |=> s_axi_bresp == `GPCFG_RESP_SLVERR && $stable(pin_enable_bit) && $stable(pin_direction_bit))
      else $error("Unmapped write not refused");

   chk_dir_read: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && s_axi_arvalid && s_axi_arready && rd_sel == GPCFG_REG_DIRECTION
      |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(pin_direction_bit))
      else $error("Direction register readback wrong");

   chk_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && s_axi_arvalid && s_axi_arready && rd_sel == GPCFG_REG_NONE
      |=> s_axi_rresp == `GPCFG_RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("Unmapped read not refused");

   chk_read_answer: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read answer missing after address");

   chk_read_release: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      clk_en && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("Read channel not released after data");

   chk_freeze_hold: assert property (@(posedge clk) disable iff (!reset_n) // RL6
      !clk_en
      |=> $stable(pin_enable_bit) && $stable(pin_direction_bit) && $stable(general_io_pins_oe))
      else $error("State moved while clock enable low");

endmodule
`default_nettype wire

// ===== verification/gpcfg_board_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpcfg_board_model
(
   // Device side of the pins
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   // Board drive where the device lets go
   input  wire logic [15:0] board_drive,
   output wire logic [15:0] pin_level
);
   // The board yields to the device on driven pins
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_drive);
endmodule
`default_nettype wire

// ===== verification/general_io_pin_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpcfg_map.svh"
module general_io_pin_config_tb;
   logic        clk, reset_n, ce, awv, wv, brdy, arv, rrdy;
   logic [31:0] awa, wd, ara;
   logic [15:0] alt_out, alt_oe, board;
   wire  logic        awr, wr, bv, arr, rv;
   wire  logic [1:0]  br, rr;
   wire  logic [31:0] rd;
   wire  logic [15:0] pout, poe, pin, en_b, dir_b, inv;
   int          miscompares, n_tests;
   logic [31:0] d;
   logic [1:0]  r;
   gpcfg_top dut (.clk(clk), .reset_n(reset_n), .clk_en(ce), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .alt_out(alt_out), .alt_oe(alt_oe), .general_io_pins_in(pin),
      .general_io_pins_out(pout), .general_io_pins_oe(poe), .pin_enable_bit(en_b),
      .pin_direction_bit(dir_b), .gpio_in_value(inv));
   gpcfg_board_model board_i (.pin_out(pout), .pin_oe(poe), .board_drive(board),
      .pin_level(pin));
   task automatic complete_run();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic axi_write(input logic [31:0] a, input logic [31:0] v);
      int n;
      awa  <= a;
      wd   <= v;
      awv  <= 1'b1;
      wv   <= 1'b1;
      // Ready stays high between transfers so no edge sees it lowered and raised
      brdy <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (awv && awr)
            awv <= 1'b0;
         if (wv && wr)
            wv <= 1'b0;
         if (bv)
            break;
      end
      r = br;
      if (n == 50)
      begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic axi_read(input logic [31:0] a);
      int n;
      ara  <= a;
      arv  <= 1'b1;
      rrdy <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (arv && arr)
            arv <= 1'b0;
         if (rv)
            break;
      end
      d = rd;
      r = rr;
      if (n == 50)
      begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic test_reset();
      axi_read(`GPCFG_PIN_ENABLE_OFFSET);
      check(d, 32'h0000_0000);
      axi_read(`GPCFG_PIN_DIRECTION_OFFSET);
      check(d, 32'h0000_0000);
      check(poe, 16'h0000);
      $display("test reset done");
   endtask
   task automatic test_config();
      axi_write(`GPCFG_PIN_ENABLE_OFFSET, 32'hffff_00ff);
      check(r, `GPCFG_RESP_OKAY);
      axi_write(`GPCFG_PIN_DIRECTION_OFFSET, 32'h0000_0f0f);
      axi_read(`GPCFG_PIN_ENABLE_OFFSET);
      check(d, 32'h0000_00ff);
      axi_read(`GPCFG_PIN_DIRECTION_OFFSET);
      check(d, 32'h0000_0f0f);
      repeat (2) @(posedge clk);
      // Only enabled pins with direction 1 drive; 11:8 stay off
      check(poe, 16'h000f);
      check(en_b, 16'h00ff);
      check(dir_b, 16'h0f0f);
      $display("test config done");
   endtask
   task automatic test_alt_and_input();
      alt_oe <= 16'hffff; alt_out <= 16'ha5a5; board <= 16'hffff;
      repeat (3) @(posedge clk);
      check(poe, 16'hff0f);
      check(pout, 16'ha500);
      // Enabled inputs 7:4 see the board; outputs and disabled pins masked
      check(inv, 16'h00f0);
      axi_write(`GPCFG_PIN_ENABLE_OFFSET, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check(poe, 16'hffff);
      $display("test alternate and input done");
   endtask
   task automatic test_freeze();
      // Pins are all disabled here, so the alternate enables show through
      ce     <= 1'b0;
      alt_oe <= 16'h0000;
      repeat (3) @(posedge clk);
      check(poe, 16'hffff);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      check(poe, 16'h0000);
      $display("test freeze done");
   endtask
   task automatic test_unmapped();
      axi_write(32'h01b0_0008, 32'h0000_ffff);
      check(r, `GPCFG_RESP_SLVERR);
      axi_read(32'h01b0_0008);
      check(r, `GPCFG_RESP_SLVERR);
      check(d, 32'h0000_0000);
      axi_read(`GPCFG_PIN_DIRECTION_OFFSET);
      check(d, 32'h0000_0f0f);
      $display("test unmapped done");
   endtask
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      reset_n = 1'b0; awv = 1'b0; wv = 1'b0; brdy = 1'b0; arv = 1'b0; rrdy = 1'b0;
      ce = 1'b1;
      awa = 32'h0; wd = 32'h0; ara = 32'h0; alt_out = 16'h0; alt_oe = 16'h0;
      board = 16'h0; miscompares = 0; n_tests = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      test_reset();
      test_config();
      test_alt_and_input();
      test_freeze();
      test_unmapped();
      complete_run();
   end
endmodule
`default_nettype wire
